/* File: design/mwd_top.sv */
// motion-watch detector configuration, shadow registers and three axes
// Notes on behaviour
// (RQ1) three-bit selector picks shadow register; codes 000 and 100 pick none
// (RQ2) codes 001/010/011 reach X/Y/Z thresholds
// (RQ3) codes 101/110/111 reach X/Y/Z detection counts
// (RQ4) counter enable low: counters unused, any event wakes
// (RQ5) counter enable high: counters on for all axes
// (RQ6) bits 6:4 pick delta window; 101 and above pick bits 10:5
// (RQ7) delta above the window clamps to a valid event
// (RQ8) bit 7 holds detector in reset; hardware never clears it
// (RQ9) software pulses bit 7 after a wakeup to re-arm
// (RQ10) config register at 0x14 is read/write, zero after reset
// (RQ11) each axis threshold is an independent six-bit value
// (RQ12) software loads count registers with events minus one
// (RQ13) baseline mode uses first sample, else previous sample
// (RQ14) none-code accesses change nothing and read zero
`timescale 1ns/10ps
`default_nettype none
module mwd_top #(
    parameter int DW = mwd_pkg::MWD_DELTA_W,
    parameter int TW = mwd_pkg::MWD_TH_W
) (
    input  wire logic            CLK,
    input  wire logic            RST_B,
    input  wire logic            REG_WR,
    input  wire logic            REG_RD,
    input  wire logic [7:0]      REG_ADDR,
    input  wire logic [7:0]      REG_WDATA,
    output logic      [7:0]      REG_RDATA,
    input  wire logic            SAMPLE_VALID,
    input  wire logic [3*DW-1:0] SAMPLE_XYZ,
    input  wire logic            BASELINE_DELTA_MODE,
    output logic      [2:0]      AXIS_HIT,
    output logic                 WAKEUP
);
    import mwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // config register layout, msb first:
    //   7    detector held in reset while set, never cleared by hardware
    //   6:4  which six delta bits meet the threshold
    //   3    detection counter enable for all axes
    //   2:0  shadow register behind the threshold port
    typedef struct packed {
        logic [7:0]         config_reg;
        logic [2:0][TW-1:0] threshold;
        logic [2:0][TW-1:0] count_limit;
        logic [7:0]         rdata;
        logic               wakeup;
    } mwd_top_s;

    mwd_top_s           st;
    mwd_top_s           next_st;

    // config fields
    logic [2:0]         sel;
    logic [1:0]         axis;
    logic               sel_none;
    logic               sel_count;
    logic               detector_clr;
    logic [2:0]         mux_sel;
    logic               cnt_en;

    // bus decode
    logic               addr_config;
    logic               addr_port;
    logic               wr_config;
    logic               wr_port;
    logic               rd_config;
    logic               rd_port;
    logic [2:0]         wr_threshold;
    logic [2:0]         wr_count;
    logic [TW-1:0]      port_rdata;
    logic [7:0]         rd_mux;

    // detector side
    logic [2:0]         hit;
    logic               any_hit;
    logic [2:0][DW-1:0] axis_sample;
    genvar              g;

    ////////////////////////////////////////////////////////////////////////
    // config register fields
    always_comb begin
        sel          = st.config_reg[MWD_SEL_LSB +: 3]; // [RQ1]
        sel_none     = (sel == MWD_SEL_NONE_LO) || (sel == MWD_SEL_NONE_HI); // [RQ1]
        sel_count    = sel[2]; // [RQ3]
        axis         = 2'(sel[1:0] - 2'h1); // [RQ2]
        cnt_en       = st.config_reg[MWD_CNTEN_BIT]; // [RQ4]
        mux_sel      = st.config_reg[MWD_MUX_LSB +: 3]; // [RQ6]
        detector_clr = st.config_reg[MWD_RESET_BIT]; // [RQ8]
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode; other addresses are ignored and read zero
    always_comb begin
        addr_config = 1'b0;
        addr_port   = 1'b0;
        if (REG_ADDR == MWD_ADDR_CONFIG) begin
            addr_config = 1'b1;
        end else if (REG_ADDR == MWD_ADDR_THRESH_PORT) begin
            addr_port = 1'b1;
        end
    end

    // the none codes block every port access
    always_comb begin
        wr_config = REG_WR && addr_config; // [RQ10]
        wr_port   = REG_WR && addr_port && !sel_none; // [RQ14]
        // reads
        rd_config = REG_RD && addr_config; // [RQ10]
        rd_port   = REG_RD && addr_port && !sel_none; // [RQ14]
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow write strobes, one pair per axis
    // axis index is the low selector bits minus one
    generate
        for (g = 0; g < 3; g++) begin : gen_shadow_we
            assign wr_threshold[g] = wr_port && !sel_count && (axis == 2'(g)); // [RQ2]
            assign wr_count[g]     = wr_port && sel_count && (axis == 2'(g)); // [RQ3]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read path; port bits 7:6 are not stored and read zero
    always_comb begin
        port_rdata = '0; // [RQ14]
        // codes 000 and 100 fall through and read zero
        if (sel == 3'h1) begin
            port_rdata = st.threshold[0]; // [RQ2]
        end else if (sel == 3'h2) begin
            port_rdata = st.threshold[1]; // [RQ2]
        end else if (sel == 3'h3) begin
            port_rdata = st.threshold[2]; // [RQ2]
        end else if (sel == 3'h5) begin
            port_rdata = st.count_limit[0]; // [RQ3]
        end else if (sel == 3'h6) begin
            port_rdata = st.count_limit[1]; // [RQ3]
        end else if (sel == 3'h7) begin
            port_rdata = st.count_limit[2]; // [RQ3]
        end
        rd_mux = 8'h00;
        if (rd_config) begin
            rd_mux = st.config_reg; // [RQ10]
        end else if (rd_port) begin
            rd_mux = 8'(port_rdata); // [RQ11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wakeup is the or of the sticky hits, one register behind them
    always_comb begin
        any_hit = |hit; // [RQ5]
    end

    ////////////////////////////////////////////////////////////////////////
    // next register state; a read in the cycle of a write sees the old value
    always_comb begin
        next_st = st;
        if (wr_config) begin
            next_st.config_reg = REG_WDATA; // [RQ10]
        end
        // at most one strobe is high, so the order does not matter
        for (int a = 0; a < 3; a++) begin
            if (wr_threshold[a]) begin
                next_st.threshold[a] = REG_WDATA[TW-1:0]; // [RQ11]
            end
            if (wr_count[a]) begin
                next_st.count_limit[a] = REG_WDATA[TW-1:0]; // [RQ3]
            end
        end
        next_st.rdata  = rd_mux; // [RQ14]
        next_st.wakeup = any_hit;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; config and shadow reset values come from the package constants, read data and wakeup reset to zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st             <= '0;
            st.config_reg  <= MWD_CONFIG_RESET; // [RQ10]
            st.threshold   <= {3{TW'(MWD_SHADOW_RESET)}};
            st.count_limit <= {3{TW'(MWD_COUNT_RESET)}};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-axis detectors; X sits in the low bits of the sample word
    // all axes share the config fields; only sample and shadows differ
    generate
        for (g = 0; g < 3; g++) begin : gen_axis
            assign axis_sample[g] = SAMPLE_XYZ[g*DW +: DW];

            mwd_axis #(
                .DW (DW),
                .TW (TW)
            ) u_axis (
                .CLK                 (CLK),
                .RST_B               (RST_B),
                .clr                 (detector_clr), // [RQ8]
                .sample_valid        (SAMPLE_VALID),
                .sample              (axis_sample[g]),
                .baseline_delta_mode (BASELINE_DELTA_MODE),
                .mux                 (mux_sel),
                .cnt_en              (cnt_en),
                .threshold           (st.threshold[g]),
                .count_limit         (st.count_limit[g]),
                .hit                 (hit[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read data and wakeup are registered; the hits come from the axes
    assign REG_RDATA = st.rdata;
    assign AXIS_HIT  = hit;
    assign WAKEUP    = st.wakeup;
endmodule
`default_nettype wire

/* File: include/mwd_pkg.sv */
// constants for the motion-watch wakeup detector
`default_nettype none
package mwd_pkg;
    localparam logic [7:0] MWD_ADDR_THRESH_PORT = 8'h13;
    localparam logic [7:0] MWD_ADDR_CONFIG      = 8'h14;
    localparam logic [7:0] MWD_CONFIG_RESET     = 8'h00;
    localparam int         MWD_SEL_LSB          = 0;
    localparam int         MWD_CNTEN_BIT        = 3;
    localparam int         MWD_MUX_LSB          = 4;
    localparam int         MWD_RESET_BIT        = 7;
    localparam int         MWD_DELTA_W          = 11;
    localparam int         MWD_TH_W             = 6;
    localparam logic [2:0] MWD_MUX_MAX          = 3'h5;
    localparam logic [2:0] MWD_SEL_NONE_LO      = 3'h0;
    localparam logic [2:0] MWD_SEL_NONE_HI      = 3'h4;
    localparam logic [5:0] MWD_SHADOW_RESET     = 6'h00;
    localparam logic [5:0] MWD_COUNT_RESET      = 6'h00;
endpackage
`default_nettype wire

/* File: design/mwd_axis.sv */
// one axis: delta, windowed clamped compare and event counter
`timescale 1ns/10ps
`default_nettype none
module mwd_axis #(
    parameter int DW = 11,
    parameter int TW = 6
) (
    input  wire logic          CLK,
    input  wire logic          RST_B,
    input  wire logic          clr,
    input  wire logic          sample_valid,
    input  wire logic [DW-1:0] sample,
    input  wire logic          baseline_delta_mode,
    input  wire logic [2:0]    mux,
    input  wire logic          cnt_en,
    input  wire logic [TW-1:0] threshold,
    input  wire logic [TW-1:0] count_limit,
    output logic               hit
);
    import mwd_pkg::*;

    typedef struct packed {
        logic [DW-1:0] ref_sample;
        logic          have_ref;
        logic [TW-1:0] count;
        logic          hit;
    } mwd_axis_s;

    mwd_axis_s st;
    mwd_axis_s next_st;
    logic [DW-1:0] delta;
    logic [DW-1:0] shifted;
    logic [TW-1:0] window;
    logic          over;
    logic          event_seen;
    logic [2:0]    sh;

    always_comb begin
        next_st = st;
        sh = (mux > MWD_MUX_MAX) ? MWD_MUX_MAX : mux; // [RQ6]
        // absolute delta, baseline or previous reference [RQ13]
        delta = (sample >= st.ref_sample) ? DW'(sample - st.ref_sample) : DW'(st.ref_sample - sample);
        shifted = delta >> sh;
        window = shifted[TW-1:0];
        over = |shifted[DW-1:TW]; // [RQ7]
        event_seen = sample_valid && st.have_ref && (over || window > threshold);
        if (clr) begin
            next_st = '0; // [RQ8]
        end else if (sample_valid) begin
            if (!st.have_ref || !baseline_delta_mode) begin
                next_st.ref_sample = sample;
            end
            next_st.have_ref = 1'b1;
            if (event_seen && !st.hit) begin
                if (!cnt_en) begin
                    next_st.hit = 1'b1; // [RQ4]
                end else if (st.count >= count_limit) begin
                    next_st.hit = 1'b1; // [RQ5]
                end else begin
                    next_st.count = TW'(st.count + 1'b1);
                end
            end else if (!event_seen && cnt_en) begin
                next_st.count = MWD_COUNT_RESET;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hit = st.hit;
endmodule
`default_nettype wire

/* File: tb/mwd_props.sv */
// checker for the motion-watch detector top
`timescale 1ns/10ps
`default_nettype none
module mwd_props #(
    parameter int DW = 11
) (
    input wire logic            CLK,
    input wire logic            RST_B,
    input wire logic            REG_WR,
    input wire logic            REG_RD,
    input wire logic [7:0]      REG_ADDR,
    input wire logic [7:0]      REG_WDATA,
    input wire logic [7:0]      REG_RDATA,
    input wire logic            SAMPLE_VALID,
    input wire logic [3*DW-1:0] SAMPLE_XYZ,
    input wire logic            BASELINE_DELTA_MODE,
    input wire logic [2:0]      AXIS_HIT,
    input wire logic            WAKEUP
);
    logic [7:0] cfg;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) cfg <= 8'h00;
        else if (REG_WR && REG_ADDR == 8'h14) cfg <= REG_WDATA;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_cfg_readback: assert property (REG_RD && REG_ADDR == 8'h14 |=> REG_RDATA == $past(cfg))
        else $error("config readback wrong");
    a_none_reads_zero: assert property (REG_RD && REG_ADDR == 8'h13 && cfg[1:0] == 2'h0 |=> REG_RDATA == 8'h00)
        else $error("none code read not zero");
    a_port_upper_zero: assert property (REG_RD && REG_ADDR == 8'h13 |=> REG_RDATA[7:6] == 2'h0)
        else $error("threshold upper bits set");
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data without read");
    a_reset_clears_hits: assert property (cfg[7] |=> AXIS_HIT == 3'h0 ##1 !WAKEUP)
        else $error("hits not cleared");
    a_hit_sticky: assert property (!cfg[7] |=> (AXIS_HIT & $past(AXIS_HIT)) == $past(AXIS_HIT))
        else $error("hit dropped");
    a_hit_needs_sample: assert property (!SAMPLE_VALID |=> (AXIS_HIT & ~$past(AXIS_HIT)) == 3'h0)
        else $error("hit without sample");
    a_wake_follows_hit: assert property (1'b1 |=> WAKEUP == |$past(AXIS_HIT))
        else $error("wakeup not or of hits");
    cover property ($rose(WAKEUP));
    cover property (REG_RD && REG_ADDR == 8'h13 && cfg[2:0] == 3'h5);
    cover property (cfg[7] && AXIS_HIT != 3'h0);
endmodule
bind mwd_top mwd_props #(.DW(DW)) u_props (.CLK(CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_XYZ(SAMPLE_XYZ), .BASELINE_DELTA_MODE(BASELINE_DELTA_MODE), .AXIS_HIT(AXIS_HIT), .WAKEUP(WAKEUP));
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the motion-watch detector
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        CLK, RST_B, REG_WR, REG_RD, SAMPLE_VALID, BASELINE_DELTA_MODE, WAKEUP, rd_d;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, q[$];
    logic [32:0] SAMPLE_XYZ;
    logic [2:0]  AXIS_HIT;
    logic [5:0]  sh[8], th, cn;
    int          miscompares, checks_done, k;
    mwd_top uut (.CLK(CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_XYZ(SAMPLE_XYZ),
        .BASELINE_DELTA_MODE(BASELINE_DELTA_MODE), .AXIS_HIT(AXIS_HIT), .WAKEUP(WAKEUP));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
        @(posedge CLK) REG_WR <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        q.push_back(e);
        @(posedge CLK) {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge CLK) REG_RD <= 1'b0;
    endtask
    task automatic smp(logic [10:0] x);
        @(posedge CLK) {SAMPLE_VALID, SAMPLE_XYZ} <= {1'b1, 22'h0, x};
        @(posedge CLK) SAMPLE_VALID <= 1'b0;
    endtask
    task automatic hc(logic e);
        @(negedge CLK) chk("hit", {7'h0, e}, {5'h0, AXIS_HIT});
        @(negedge CLK) chk("wake", {7'h0, e}, {7'h0, WAKEUP});
    endtask
    task automatic arm(logic [7:0] c);
        wr(8'h14, c | 8'h80);
        rd(8'h14, c | 8'h80);
        wr(8'h14, c & 8'h7F);
    endtask
    task print_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // read data lands one cycle after the strobe
    always @(negedge CLK) begin
        if (rd_d) chk("rdata", q.pop_front(), REG_RDATA);
        rd_d <= REG_RD;
    end
    initial begin CLK = 1'b0; forever #50 CLK = ~CLK; end
    initial begin #2000000; miscompares++; print_verdict; end
    initial begin
        {RST_B, REG_WR, REG_RD, SAMPLE_VALID, BASELINE_DELTA_MODE} = 5'h00;
        {REG_ADDR, REG_WDATA, SAMPLE_XYZ} = 49'h0;
        k = $urandom(38237);
        repeat (4) @(posedge CLK);
        RST_B <= 1'b1;
        rd(8'h14, 8'h00);
        arm(8'($urandom));
        th = 6'($urandom % 63);
        cn = 6'($urandom % 8);
        for (int s = 0; s < 16; s++) begin
            if (s < 8) sh[s] = (s == 1) ? th : (s == 5) ? cn : 6'($urandom);
            wr(8'h14, 8'(s % 8));
            if (s < 8) wr(8'h13, {2'h3, sh[s]});
            else rd(8'h13, (s % 4 == 0) ? 8'h00 : {2'h0, sh[s - 8]});
        end
        $display("test shadow routing done");
        BASELINE_DELTA_MODE <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            k = (m > 5) ? 5 : m;
            arm(8'(m << 4));
            smp(11'h0);
            smp(11'(th) << k);
            hc(1'b0);
            smp((11'(th) + 11'h1) << k);
            hc(1'b1);
        end
        BASELINE_DELTA_MODE <= 1'b0;
        arm(8'h00);
        smp(11'h0);
        smp(11'(th));
        smp(11'(th) << 1);
        hc(1'b0);
        smp(11'h7FF);
        hc(1'b1);
        $display("test window and delta done");
        BASELINE_DELTA_MODE <= 1'b1;
        arm(8'h08);
        hc(1'b0);
        smp(11'h0);
        repeat (cn) smp(11'h7FF);
        hc(1'b0);
        smp(11'h7FF);
        hc(1'b1);
        $display("test counter done");
        print_verdict;
    end
endmodule
`default_nettype wire
